// *** design/dlc_cfg.svh ***
`ifndef DLC_CFG_SVH
`define DLC_CFG_SVH

// ==========================================================
// Control byte layout
`define DLC_SEL_HI 7
`define DLC_SEL_LO 6
`define DLC_LVL_STEP_HI 2
`define DLC_LVL_STEP_LO 0
`define DLC_LVL_RANGE_BIT 3
`define DLC_LVL_OCT_BIT 4
`define DLC_LVL_EN_BIT 5
`define DLC_TONE_SRC_BIT 0
`define DLC_TONE_GATE_BIT 1
`define DLC_TONE_CAB_BIT 2

// ==========================================================
// Register select codes
`define DLC_SEL_LVL_CH1 2'h0
`define DLC_SEL_LVL_CH2 2'h1
`define DLC_SEL_TONE_CH1 2'h2
`define DLC_SEL_TONE_CH2 2'h3

// ==========================================================
// Reset values
`define DLC_LVL_RESET 6'h00
`define DLC_TONE_RESET 3'h0
`define DLC_OFF_FLAG_RESET 2'h3

// ==========================================================
// Analog targets in millivolts
`define DLC_BASE_LOW_MV 16'h31A5
`define DLC_BASE_HIGH_MV 16'h467A
`define DLC_STEP_MV 16'h014D
`define DLC_CAB_BOOST_MV 16'h5910

// ==========================================================
// Timing
`define DLC_CLK_HZ 125000000
`define DLC_TONE_HZ 22000
`define DLC_TONE_HALF_CYC ((`DLC_CLK_HZ) / (2 * `DLC_TONE_HZ))

`endif

// *** design/dlc_pkg.sv ***
package dlc_pkg;

  // ==========================================================
  // Register select, in the order of the two select bits
  typedef enum logic [1:0]
  {
    DLC_REG_LVL_CH1,
    DLC_REG_LVL_CH2,
    DLC_REG_TONE_CH1,
    DLC_REG_TONE_CH2
  } dlc_reg_sel_t;

  // ==========================================================
  // Stored control fields of one channel
  typedef struct packed
  {
    logic output_enable;
    logic overcurrent_timer_ctl;
    logic range_select;
    logic [2:0] level_step;
  } dlc_level_t;

  typedef struct packed
  {
    logic cable_test_on;
    logic tone_gate;
    logic tone_source_sel;
  } dlc_tone_t;

endpackage : dlc_pkg

// *** design/dlc_tone_if.sv ***
`timescale 1ns/1ns

// ==========================================================
// Tone path controls between the register bank and the tone generator
interface dlc_tone_if;
  logic [1:0] tone_source_sel;
  logic [1:0] tone_gate;
  logic [1:0] ext_gate_sel;
  logic [1:0] ext_modulation_in;
  logic [1:0] ext_tone;
  logic [1:0] tone;

  modport ctrl
  (
    output tone_source_sel,
    output tone_gate,
    output ext_gate_sel,
    output ext_modulation_in,
    output ext_tone,
    input tone
  );

  modport gen
  (
    input tone_source_sel,
    input tone_gate,
    input ext_gate_sel,
    input ext_modulation_in,
    input ext_tone,
    output tone
  );
endinterface : dlc_tone_if

// *** design/dlc_tone_gen.sv ***
`timescale 1ns/1ns
`include "dlc_cfg.svh"

// ==========================================================
// Internal tone oscillator and per-channel source select and gating
module dlc_tone_gen #(
  parameter int HALF_CYC = `DLC_TONE_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  dlc_tone_if.gen tif
);

  logic [15:0] half_cnt;
  logic half_tick;
  logic int_tone;
  logic [1:0] src_tone;
  logic [1:0] gate_on;
  logic [1:0] next_tone;

  // ==========================================================
  // Oscillator: toggles every half period
  assign half_tick = (half_cnt == 16'(HALF_CYC - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      half_cnt <= 16'h0000;
      int_tone <= 1'b0;
    end
    else if (half_tick)
    begin
      half_cnt <= 16'h0000;
      int_tone <= ~int_tone;
    end
    else
    begin
      half_cnt <= half_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Source select and gating
  assign src_tone = (tif.tone_source_sel & {2{int_tone}}) |
                    (~tif.tone_source_sel & tif.ext_tone);
  assign gate_on = (tif.ext_gate_sel & tif.ext_modulation_in) |
                   (~tif.ext_gate_sel & tif.tone_gate);
  assign next_tone = src_tone & gate_on;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      tif.tone <= 2'h0;
    else
      tif.tone <= next_tone;
  end

endmodule : dlc_tone_gen

// *** design/dlc_regs.sv ***
`timescale 1ns/1ns
`include "dlc_cfg.svh"

module dlc_regs #(
  parameter int TONE_HALF_CYC = `DLC_TONE_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_end_i,
  input wire logic [1:0] ext_tone_i,
  input wire logic [1:0] ext_modulation_in_i,
  input wire logic [1:0] ext_gate_sel_i,
  input wire logic [1:0] cmp_above_21v_i,
  input wire logic [1:0] cmp_below_19v95_i,
  input wire logic [1:0] ocp_fault_i,
  output logic [7:0] level_code_o,
  output logic [31:0] level_mv_o,
  output logic [31:0] boost_mv_o,
  output logic [1:0] output_enable_o,
  output logic [1:0] lin_reg_en_o,
  output logic [1:0] sense_src_en_o,
  output logic [1:0] ocp_timer_en_o,
  output logic [1:0] overcurrent_timer_ctl_o,
  output logic [1:0] tone_o,
  output logic [1:0] cable_missing_flag_o,
  output logic [1:0] output_off_flag_o
);

  // ==========================================================
  // Functions
  // Levels as tabulated: whole 333 mV steps drift from the listed values
  function automatic logic [15:0] dlc_level_mv(input logic [3:0] code);
    case (code)
      4'h0: dlc_level_mv = `DLC_BASE_LOW_MV;
      4'h1: dlc_level_mv = 16'h32F2;
      4'h2: dlc_level_mv = 16'h343F;
      4'h3: dlc_level_mv = 16'h358D;
      4'h4: dlc_level_mv = 16'h36DA;
      4'h5: dlc_level_mv = 16'h3827;
      4'h6: dlc_level_mv = 16'h3975;
      4'h7: dlc_level_mv = 16'h3AC2;
      4'h8: dlc_level_mv = `DLC_BASE_HIGH_MV;
      4'h9: dlc_level_mv = 16'h47C7;
      4'hA: dlc_level_mv = 16'h4915;
      4'hB: dlc_level_mv = 16'h4A62;
      4'hC: dlc_level_mv = 16'h4BAF;
      4'hD: dlc_level_mv = 16'h4CFD;
      4'hE: dlc_level_mv = 16'h4E4A;
      default: dlc_level_mv = 16'h4F97;
    endcase
  endfunction : dlc_level_mv

  function automatic logic dlc_hit(input logic [1:0] sel, input logic [1:0] code);
    dlc_hit = (sel == code);
  endfunction : dlc_hit

  // ==========================================================
  // Stored controls
  dlc_pkg::dlc_level_t lvl [2];
  dlc_pkg::dlc_tone_t tone_ctl [2];
  dlc_pkg::dlc_reg_sel_t wr_sel;

  logic [1:0] sel_bits;
  logic [1:0] wr_lvl;
  logic [1:0] wr_tone;
  logic [5:0] wr_payload;
  logic [1:0] en_now;
  logic [1:0] cab_now;
  logic [1:0] next_cab;
  logic [1:0] next_off;
  logic [1:0] off_set;
  logic [1:0] off_clr;

  dlc_tone_if tif ();

  // ==========================================================
  // Write decode
  assign sel_bits = wr_data_i[`DLC_SEL_HI:`DLC_SEL_LO];
  assign wr_sel = dlc_pkg::dlc_reg_sel_t'(sel_bits);
  assign wr_payload = wr_data_i[5:0];
  assign wr_lvl[0] = wr_valid_i && dlc_hit(wr_sel, `DLC_SEL_LVL_CH1);
  assign wr_lvl[1] = wr_valid_i && dlc_hit(wr_sel, `DLC_SEL_LVL_CH2);
  assign wr_tone[0] = wr_valid_i && dlc_hit(wr_sel, `DLC_SEL_TONE_CH1);
  assign wr_tone[1] = wr_valid_i && dlc_hit(wr_sel, `DLC_SEL_TONE_CH2);

  // A later byte in the same transaction simply overwrites; the master keeps one
  // byte per addressed write

  // ==========================================================
  // Control registers
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ctl
    always_ff @(posedge clk_sys_i)
    begin
      if (sys_rst_i)
      begin
        lvl[ch] <= dlc_pkg::dlc_level_t'(`DLC_LVL_RESET);
        tone_ctl[ch] <= dlc_pkg::dlc_tone_t'(`DLC_TONE_RESET);
      end
      else
      begin
        if (wr_lvl[ch])
        begin
          lvl[ch].level_step <= wr_payload[`DLC_LVL_STEP_HI:`DLC_LVL_STEP_LO];
          lvl[ch].range_select <= wr_payload[`DLC_LVL_RANGE_BIT];
          lvl[ch].overcurrent_timer_ctl <= wr_payload[`DLC_LVL_OCT_BIT];
          lvl[ch].output_enable <= wr_payload[`DLC_LVL_EN_BIT];
        end
        if (wr_tone[ch])
        begin
          // Upper payload bits are dropped here
          tone_ctl[ch].tone_source_sel <= wr_payload[`DLC_TONE_SRC_BIT];
          tone_ctl[ch].tone_gate <= wr_payload[`DLC_TONE_GATE_BIT];
          tone_ctl[ch].cable_test_on <= wr_payload[`DLC_TONE_CAB_BIT];
        end
      end
    end

    assign en_now[ch] = lvl[ch].output_enable;
    assign cab_now[ch] = tone_ctl[ch].cable_test_on;
  end

  // ==========================================================
  // Cable-disconnect flag
  // Set wins over clear when both comparators report in one cycle
  assign next_cab = cab_now & (cmp_above_21v_i |
                    (cable_missing_flag_o & ~cmp_below_19v95_i));

  // ==========================================================
  // Output-off flag
  // Held while disabled or faulted; released only at a write end
  assign off_set = ~en_now | ocp_fault_i;
  assign off_clr = {2{wr_end_i}} & en_now & ~ocp_fault_i;
  assign next_off = off_set | (output_off_flag_o & ~off_clr);

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      cable_missing_flag_o <= 2'h0;
      output_off_flag_o <= `DLC_OFF_FLAG_RESET;
    end
    else
    begin
      cable_missing_flag_o <= next_cab;
      output_off_flag_o <= next_off;
    end
  end

  // ==========================================================
  // Analog drive
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_drv
    logic [3:0] code;
    logic [15:0] lvl_mv;

    assign code = {lvl[ch].range_select, lvl[ch].level_step};
    assign lvl_mv = dlc_level_mv(code);

    always_ff @(posedge clk_sys_i)
    begin
      if (sys_rst_i)
      begin
        level_code_o[ch*4 +: 4] <= 4'h0;
        level_mv_o[ch*16 +: 16] <= `DLC_BASE_LOW_MV;
        boost_mv_o[ch*16 +: 16] <= `DLC_BASE_LOW_MV;
        output_enable_o[ch] <= 1'b0;
        lin_reg_en_o[ch] <= 1'b0;
        sense_src_en_o[ch] <= 1'b0;
        ocp_timer_en_o[ch] <= 1'b1;
        overcurrent_timer_ctl_o[ch] <= 1'b0;
      end
      else
      begin
        level_code_o[ch*4 +: 4] <= code;
        level_mv_o[ch*16 +: 16] <= lvl_mv;
        boost_mv_o[ch*16 +: 16] <= cab_now[ch] ? `DLC_CAB_BOOST_MV : lvl_mv;
        output_enable_o[ch] <= en_now[ch];
        lin_reg_en_o[ch] <= en_now[ch] & ~cab_now[ch];
        sense_src_en_o[ch] <= cab_now[ch];
        ocp_timer_en_o[ch] <= 1'b1;
        overcurrent_timer_ctl_o[ch] <= lvl[ch].overcurrent_timer_ctl;
      end
    end
  end

  // ==========================================================
  // Tone path
  assign tif.tone_source_sel = {tone_ctl[1].tone_source_sel, tone_ctl[0].tone_source_sel};
  assign tif.tone_gate = {tone_ctl[1].tone_gate, tone_ctl[0].tone_gate};
  assign tif.ext_gate_sel = ext_gate_sel_i;
  assign tif.ext_modulation_in = ext_modulation_in_i;
  assign tif.ext_tone = ext_tone_i;
  assign tone_o = tif.tone;

  dlc_tone_gen #(
    .HALF_CYC(TONE_HALF_CYC)
  ) u_tone (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .tif(tif.gen)
  );

endmodule : dlc_regs

// *** test/dlc_wr_master.sv ***
`timescale 1ns/1ns

// ==========================================================
// Write-side bus master: one control byte per addressed write
module dlc_wr_master (
  input wire logic clk_sys_i,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o,
  output logic wr_end_o
);
  initial
  begin
    wr_valid_o = 1'b0;
    wr_data_o = 8'h00;
    wr_end_o = 1'b0;
  end

  task automatic send(input logic [7:0] b);
    @(posedge clk_sys_i);
    wr_valid_o <= 1'b1;
    wr_data_o <= b;
    @(posedge clk_sys_i);
    wr_valid_o <= 1'b0;
    wr_data_o <= ~b;
    @(posedge clk_sys_i);
    wr_end_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_end_o <= 1'b0;
  endtask : send
endmodule : dlc_wr_master

// *** test/dlc_regs_properties.sv ***
`timescale 1ns/1ns

// ==========================================================
// Port-level checks of the control register bank
module dlc_regs_properties (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_end_i,
  input wire logic [1:0] ext_modulation_in_i,
  input wire logic [1:0] ext_gate_sel_i,
  input wire logic [1:0] cmp_above_21v_i,
  input wire logic [1:0] cmp_below_19v95_i,
  input wire logic [1:0] ocp_fault_i,
  input wire logic [7:0] level_code_o,
  input wire logic [31:0] boost_mv_o,
  input wire logic [1:0] output_enable_o,
  input wire logic [1:0] lin_reg_en_o,
  input wire logic [1:0] sense_src_en_o,
  input wire logic [1:0] ocp_timer_en_o,
  input wire logic [1:0] tone_o,
  input wire logic [1:0] cable_missing_flag_o,
  input wire logic [1:0] output_off_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_ocp_timer;
    ocp_timer_en_o == 2'h3;
  endproperty
  a_ocp_timer: assert property (p_ocp_timer) else $error("timer enable dropped");
  property p_lvl_ch1;
    wr_valid_i && wr_data_i[7:6] == 2'h0 |-> ##2 level_code_o[3:0] == $past(wr_data_i[3:0], 2);
  endproperty
  a_lvl_ch1: assert property (p_lvl_ch1) else $error("ch1 level code wrong");
  property p_lvl_ch2;
    wr_valid_i && wr_data_i[7:6] == 2'h1 |-> ##2 output_enable_o[1] == $past(wr_data_i[5], 2);
  endproperty
  a_lvl_ch2: assert property (p_lvl_ch2) else $error("ch2 enable wrong");
  property p_cab_wr;
    wr_valid_i && wr_data_i[7:6] == 2'h2 |-> ##2 sense_src_en_o[0] == $past(wr_data_i[2], 2);
  endproperty
  a_cab_wr: assert property (p_cab_wr) else $error("ch1 test bit wrong");
  property p_lin;
    lin_reg_en_o == (output_enable_o & ~sense_src_en_o);
  endproperty
  a_lin: assert property (p_lin) else $error("regulator enable wrong");
  property p_boost;
    sense_src_en_o[0] |-> boost_mv_o[15:0] == 16'h5910;
  endproperty
  a_boost: assert property (p_boost) else $error("boost target wrong");
  property p_cab_set;
    sense_src_en_o[0] && cmp_above_21v_i[0] ##1 sense_src_en_o[0] |-> cable_missing_flag_o[0];
  endproperty
  a_cab_set: assert property (p_cab_set) else $error("cable flag not set");
  property p_cab_clr;
    sense_src_en_o[0] && cmp_below_19v95_i[0] && !cmp_above_21v_i[0] |=> !cable_missing_flag_o[0];
  endproperty
  a_cab_clr: assert property (p_cab_clr) else $error("cable flag not cleared");
  property p_off_clr;
    wr_end_i && !ocp_fault_i[0] ##1 output_enable_o[0] |-> !output_off_flag_o[0];
  endproperty
  a_off_clr: assert property (p_off_clr) else $error("off flag kept");
  property p_ext_gate;
    ext_gate_sel_i[1] && !ext_modulation_in_i[1] |=> !tone_o[1];
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("tone not gated");
endmodule : dlc_regs_properties

bind dlc_regs dlc_regs_properties u_dlc_regs_properties (.*);

// *** test/dual_lnb_control_regs_tb_top.sv ***
`timescale 1ns/1ns

module dual_lnb_control_regs_tb_top;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wv, we;
  logic [7:0] wd, lc;
  logic [1:0] et = 2'h0, em = 2'h0, es = 2'h0, ab = 2'h0, bl = 2'h0, fl = 2'h0;
  logic [31:0] lm, bm, r;
  logic [1:0] oen, lin, sen, oce, oct, tn, cab, off;
  logic [31:0] seed = 32'h296B8D26;
  logic [15:0] mvt [16] = '{16'h31A5, 16'h32F2, 16'h343F, 16'h358D, 16'h36DA, 16'h3827,
    16'h3975, 16'h3AC2, 16'h467A, 16'h47C7, 16'h4915, 16'h4A62, 16'h4BAF, 16'h4CFD,
    16'h4E4A, 16'h4F97};
  int miscompares = 0;
  int checks = 0;
  int n;

  always #4 clk_sys_i = ~clk_sys_i;

  dlc_wr_master u_dlc_wr_master (.clk_sys_i(clk_sys_i), .wr_valid_o(wv), .wr_data_o(wd),
    .wr_end_o(we));
  dlc_regs #(.TONE_HALF_CYC(4)) u_dlc_regs (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .wr_valid_i(wv), .wr_data_i(wd), .wr_end_i(we), .ext_tone_i(et),
    .ext_modulation_in_i(em), .ext_gate_sel_i(es), .cmp_above_21v_i(ab),
    .cmp_below_19v95_i(bl), .ocp_fault_i(fl), .level_code_o(lc), .level_mv_o(lm),
    .boost_mv_o(bm), .output_enable_o(oen), .lin_reg_en_o(lin), .sense_src_en_o(sen),
    .ocp_timer_en_o(oce), .overcurrent_timer_ctl_o(oct), .tone_o(tn),
    .cable_missing_flag_o(cab), .output_off_flag_o(off));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Write one byte and let the outputs settle
  task automatic wr(input logic [7:0] b);
    u_dlc_wr_master.send(b);
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : wr

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : cyc

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    cyc(1);
    chk(lm, 32'h31A531A5);
    chk({lc, off, oce, oen, sen, tn, cab}, 20'h00F00);
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      wr({1'b0, r[0], 1'b1, r[1], i[3:0]});
      chk(lm[r[0]*16 +: 16], mvt[i]);
      chk({lc[r[0]*4 +: 4], oen[r[0]], off[r[0]], oct[r[0]]}, {i[3:0], 2'h2, r[1]});
    end
    wr(8'h00);
    chk({oen[0], lin[0], off[0]}, 3'h1);
    @(posedge clk_sys_i);
    fl[1] <= 1'b1;
    wr(8'h40);
    wr(8'h60);
    chk(off[1], 1'b1);
    @(posedge clk_sys_i);
    fl[1] <= 1'b0;
    wr(8'h28);
    chk(off, 2'h0);
    r = rnd();
    wr({2'h2, r[5:3], 3'h4});
    chk({sen[0], lin[0], bm[15:0]}, 18'h25910);
    chk(lm[15:0], 16'h467A);
    @(posedge clk_sys_i);
    ab[0] <= 1'b1;
    cyc(2);
    chk(cab[0], 1'b1);
    @(posedge clk_sys_i);
    ab[0] <= 1'b0;
    bl[0] <= 1'b1;
    cyc(2);
    chk(cab[0], 1'b0);
    wr(8'h80);
    chk({sen[0], bm[15:0]}, 17'h0467A);
    wr(8'hC2);
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      @(posedge clk_sys_i);
      et <= r[1:0];
      em[1] <= r[2];
      es[1] <= i > 5;
      cyc(1);
      chk(tn[1], (i > 5) ? r[1] & r[2] : r[1]);
    end
    @(posedge clk_sys_i);
    es <= 2'h0;
    et <= 2'h3;
    wr(8'hC0);
    chk(tn[1], 1'b0);
    wr(8'hC3);
    n = 0;
    for (int i = 0; i < 40; i++)
    begin
      r[0] = tn[1];
      cyc(1);
      n += (tn[1] !== r[0]);
    end
    chk(n >= 8, 1'b1);
    report_and_stop();
  end
endmodule : dual_lnb_control_regs_tb_top
